// ===== logic/spi_sel_defines.svh
// register offsets, field positions, reset values and core clock rate
`ifndef SPI_SEL_DEFINES_SVH
`define SPI_SEL_DEFINES_SVH
`define OFS_CONTROL      3'h0
`define OFS_STATUS       3'h1
`define OFS_DATA         3'h2
`define OFS_IRQ_STATUS   3'h3
`define OFS_IRQ_ENABLE   3'h4
`define OFS_IRQ_CLEAR    3'h5
`define OFS_PIN_DIR      3'h6
`define OFS_PIN_STATE    3'h7
`define BIT_IRQ_EN       7
`define BIT_MOD_EN       6
`define BIT_ORDER        5
`define BIT_MASTER       4
`define BIT_CPOL         3
`define BIT_CPHA         2
`define BIT_RATE_HI      1
`define BIT_RATE_LO      0
`define BIT_FLAG         7
`define BIT_WCOL         6
`define BIT_DSPEED       0
`define EV_DONE          0
`define EV_FAULT         1
`define EV_WCOL          2
`define DIR_MOSI         0
`define DIR_MISO         1
`define DIR_SCK          2
`define DIR_SS           3
`define CONTROL_RESET    8'h00
`define STATUS_RESET     8'h00
`define SYS_CLK_MHZ      25
`endif

// ===== logic/spi_sel_pkg.sv
// types shared by the select and control block
package spi_sel_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } mstate_t;
  typedef logic [7:0] byte_t;
endpackage : spi_sel_pkg

// ===== logic/pin_sync.sv
// two flip-flop synchroniser for the link pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;
  // first stage read only by the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule : pin_sync

// ===== logic/spi_select_and_control.sv
// slave-select handling, master/slave roles and control register of the serial port
`timescale 1ns/1ps
`include "spi_sel_defines.svh"

module spi_select_and_control
  import spi_sel_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       global_irq_en,
  output logic            irq,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_n,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe_n,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe_n,
  input  wire logic       ss_in,
  output logic            ss_out,
  output logic            ss_oe_n
);

  // ****************************************
  // helpers
  // ****************************************
  // half period of SCK in core clocks for the rate code
  function automatic logic [6:0] half_div(input logic [2:0] code);
    unique case (code)
      3'h0: half_div = 7'h02;
      3'h1: half_div = 7'h08;
      3'h2: half_div = 7'h20;
      3'h3: half_div = 7'h40;
      3'h4: half_div = 7'h01;
      3'h5: half_div = 7'h04;
      3'h6: half_div = 7'h10;
      default: half_div = 7'h20;
    endcase
  endfunction : half_div

  // bit that leaves first for the chosen order
  function automatic logic top_bit(input logic lsb, input byte_t b);
    top_bit = lsb ? b[0] : b[7];
  endfunction : top_bit

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pins_s;
  pin_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({ss_in, miso_in, mosi_in, sck_in}),
    .sync_out (pins_s)
  );
  logic sck_s, mosi_s, miso_s, ss_s;
  assign sck_s  = pins_s[0];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[2];
  assign ss_s   = pins_s[3];

  // ****************************************
  // state
  // ****************************************
  byte_t      ctrl_q, ctrl_d;
  logic       dspeed_q, dspeed_d;
  logic       flag_q, flag_d;
  logic       wcol_q, wcol_d;
  logic       stat_rd_q, stat_rd_d;
  byte_t      rxbuf_q, rxbuf_d;
  byte_t      shift_q, shift_d;
  logic [3:0] bits_q, bits_d;
  logic [3:0] dir_q, dir_d;
  logic       ss_lvl_q, ss_lvl_d;
  logic [2:0] ev_q, ev_d;
  logic [2:0] ev_en_q, ev_en_d;
  logic       sck_prev_q, sck_prev_d;
  logic       ss_prev_q, ss_prev_d;
  logic       msck_q, msck_d;
  logic [6:0] div_q, div_d;
  logic       edge2_q, edge2_d;
  logic       obit_q, obit_d;
  mstate_t    mst_q, mst_d;
  byte_t      rdata_d;
  logic       irq_d;
  logic       sck_out_d, sck_oe_n_d, mosi_out_d, mosi_oe_n_d;
  logic       miso_out_d, miso_oe_n_d, ss_out_d, ss_oe_n_d;

  logic en, master, lsb_first, cpol, cpha;
  assign en        = ctrl_q[`BIT_MOD_EN];
  assign master    = ctrl_q[`BIT_MASTER];
  assign lsb_first = ctrl_q[`BIT_ORDER];
  assign cpol      = ctrl_q[`BIT_CPOL];
  assign cpha      = ctrl_q[`BIT_CPHA];

  // ****************************************
  // next state
  // ****************************************
  // slave-side edges seen by sampling SCK; link must stay below core_clk/4
  always_comb begin
    logic fault, slave_act, lead, trail, smp, setup, done, ss_rise, data_acc;
    logic out_bit;
    fault = 1'b0; slave_act = 1'b0; lead = 1'b0; trail = 1'b0;
    smp = 1'b0; setup = 1'b0; done = 1'b0; ss_rise = 1'b0; data_acc = 1'b0;
    out_bit = 1'b0;
    ctrl_d = ctrl_q; dspeed_d = dspeed_q; flag_d = flag_q; wcol_d = wcol_q;
    stat_rd_d = stat_rd_q; rxbuf_d = rxbuf_q; shift_d = shift_q; bits_d = bits_q;
    dir_d = dir_q; ss_lvl_d = ss_lvl_q; ev_en_d = ev_en_q;
    sck_prev_d = sck_s; ss_prev_d = ss_s; msck_d = msck_q; div_d = div_q;
    edge2_d = edge2_q; mst_d = mst_q; rdata_d = 8'h00; obit_d = obit_q;
    ev_d = ev_q;
    // software writes first so hardware events below win over them
    if (wr) begin
      unique case (addr)
        `OFS_CONTROL: ctrl_d = wdata;
        `OFS_STATUS: dspeed_d = wdata[`BIT_DSPEED];
        `OFS_DATA: begin
          data_acc = 1'b1;
          if (mst_q != ST_IDLE || (!master && !ss_s && bits_q != 4'h0))
            wcol_d = 1'b1;
          else
            shift_d = wdata;
        end
        `OFS_IRQ_ENABLE: ev_en_d = wdata[2:0];
        `OFS_IRQ_CLEAR: ev_d = ev_q & ~wdata[2:0];
        `OFS_PIN_DIR: dir_d = wdata[3:0];
        `OFS_PIN_STATE: ss_lvl_d = wdata[0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        `OFS_CONTROL: rdata_d = ctrl_q;
        `OFS_STATUS: begin
          rdata_d = {flag_q, wcol_q, 5'h00, dspeed_q};
          stat_rd_d = flag_q | wcol_q;
        end
        `OFS_DATA: begin
          rdata_d = rxbuf_q;
          data_acc = 1'b1;
        end
        `OFS_IRQ_STATUS: rdata_d = {5'h00, ev_q};
        `OFS_IRQ_ENABLE: rdata_d = {5'h00, ev_en_q};
        `OFS_PIN_DIR: rdata_d = {4'h0, dir_q};
        `OFS_PIN_STATE: rdata_d = {4'h0, ss_s, miso_s, mosi_s, sck_s};
        default: rdata_d = 8'h00;
      endcase
    end
    // status read then data access clears the flags
    if (data_acc && stat_rd_q) begin
      flag_d = 1'b0;
      wcol_d = 1'b0;
      stat_rd_d = 1'b0;
    end
    lead  = (sck_s != sck_prev_q) && (sck_s != cpol);
    trail = (sck_s != sck_prev_q) && (sck_s == cpol);
    ss_rise = ss_s && !ss_prev_q;
    if (!en) begin
      // disabled: no serial activity at all
      mst_d = ST_IDLE;
      bits_d = 4'h0;
      msck_d = cpol;
      obit_d = top_bit(lsb_first, shift_d);
    end else if (master) begin
      // select input low means another master
      if (!dir_q[`DIR_SS] && !ss_s) begin
        fault = 1'b1;
        ctrl_d[`BIT_MASTER] = 1'b0;
        flag_d = 1'b1;
        mst_d = ST_IDLE;
        bits_d = 4'h0;
        msck_d = cpol;
      end else begin
        unique case (mst_q)
          ST_IDLE: begin
            msck_d = cpol;
            div_d = 7'h00;
            edge2_d = 1'b0;
            bits_d = 4'h0;
            if (wr && addr == `OFS_DATA) mst_d = ST_SHIFT;
          end
          ST_SHIFT: begin
            if (div_q + 7'h01 >= half_div({dspeed_q, ctrl_q[1:0]})) begin
              div_d = 7'h00;
              msck_d = ~msck_q;
              edge2_d = ~edge2_q;
              if (!edge2_q) smp = !cpha; else smp = cpha;
              if (!edge2_q) setup = cpha && bits_q != 4'h0; else setup = !cpha;
              if (edge2_q && bits_q == 4'h7) mst_d = ST_DONE;
              if (edge2_q) bits_d = bits_q + 4'h1;
            end else begin
              div_d = div_q + 7'h01;
            end
          end
          ST_DONE: begin
            done = 1'b1;
            mst_d = ST_IDLE;
          end
          default: mst_d = ST_IDLE;
        endcase
        if (smp) begin
          if (lsb_first) shift_d = {miso_s, shift_q[7:1]};
          else shift_d = {shift_q[6:0], miso_s};
        end
        // MOSI moves on a setup edge or while idle, so the far side never sees it change while sampling
        if (setup) obit_d = top_bit(lsb_first, shift_q);
        if (mst_q == ST_IDLE) obit_d = top_bit(lsb_first, shift_d);
      end
    end else begin
      mst_d = ST_IDLE;
      slave_act = !ss_s;
      if (ss_rise || ss_s) bits_d = 4'h0;
      if (slave_act) begin
        smp = cpha ? trail : lead;
        setup = cpha ? lead : trail;
        if (smp) begin
          if (lsb_first) shift_d = {mosi_s, shift_q[7:1]};
          else shift_d = {shift_q[6:0], mosi_s};
          bits_d = bits_q + 4'h1;
          if (bits_q == 4'h7) begin
            done = 1'b1;
            bits_d = 4'h0;
          end
        end else if (setup && !(cpha && bits_q == 4'h0) && bits_q != 4'h0) begin
          // shift already advanced on sample; next bit presented by the shift that took in MOSI
        end
      end
    end
    if (done) begin
      rxbuf_d = shift_d;
      flag_d = 1'b1;
    end
    // hardware sets win over software clears
    ev_d = ev_d | {wcol_d & ~wcol_q, fault, done};
    irq_d = |(ev_q & ev_en_q) ||
            (flag_q && ctrl_q[`BIT_IRQ_EN] && global_irq_en);
    out_bit = top_bit(lsb_first, shift_q);
    // pin directions; open enables are active low
    sck_out_d = msck_q; mosi_out_d = obit_q; miso_out_d = out_bit; ss_out_d = ss_lvl_q;
    sck_oe_n_d = 1'b1; mosi_oe_n_d = 1'b1; miso_oe_n_d = 1'b1; ss_oe_n_d = 1'b1;
    if (en && master && !fault) begin
      sck_oe_n_d  = !dir_q[`DIR_SCK];
      mosi_oe_n_d = !dir_q[`DIR_MOSI];
      ss_oe_n_d   = !dir_q[`DIR_SS];
    end else if (en && !master && slave_act) begin
      miso_oe_n_d = !dir_q[`DIR_MISO];
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= `CONTROL_RESET;
      dspeed_q <= 1'b0; flag_q <= 1'b0; wcol_q <= 1'b0; stat_rd_q <= 1'b0;
      rxbuf_q <= 8'h00; shift_q <= 8'h00; bits_q <= 4'h0; dir_q <= 4'h0;
      ss_lvl_q <= 1'b1; ev_q <= 3'h0; ev_en_q <= 3'h0; sck_prev_q <= 1'b0;
      ss_prev_q <= 1'b1; msck_q <= 1'b0; div_q <= 7'h00; edge2_q <= 1'b0;
      mst_q <= ST_IDLE; rdata <= 8'h00; irq <= 1'b0; obit_q <= 1'b0;
      sck_out <= 1'b0; sck_oe_n <= 1'b1; mosi_out <= 1'b0; mosi_oe_n <= 1'b1;
      miso_out <= 1'b0; miso_oe_n <= 1'b1; ss_out <= 1'b1; ss_oe_n <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      dspeed_q <= dspeed_d; flag_q <= flag_d; wcol_q <= wcol_d; stat_rd_q <= stat_rd_d;
      rxbuf_q <= rxbuf_d; shift_q <= shift_d; bits_q <= bits_d; dir_q <= dir_d;
      ss_lvl_q <= ss_lvl_d; ev_q <= ev_d; ev_en_q <= ev_en_d; sck_prev_q <= sck_prev_d;
      ss_prev_q <= ss_prev_d; msck_q <= msck_d; div_q <= div_d; edge2_q <= edge2_d;
      mst_q <= mst_d; rdata <= rdata_d; irq <= irq_d; obit_q <= obit_d;
      sck_out <= sck_out_d; sck_oe_n <= sck_oe_n_d; mosi_out <= mosi_out_d;
      mosi_oe_n <= mosi_oe_n_d; miso_out <= miso_out_d; miso_oe_n <= miso_oe_n_d;
      ss_out <= ss_out_d; ss_oe_n <= ss_oe_n_d;
    end
  end

endmodule : spi_select_and_control

// ===== tb/spi_sel_checker.sv
// port assertions for the select and control block
`timescale 1ns/1ps
`include "spi_sel_defines.svh"
module spi_sel_checker
  import spi_sel_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       global_irq_en,
  input wire logic       irq,
  input wire logic       sck_oe_n,
  input wire logic       mosi_oe_n,
  input wire logic       miso_oe_n,
  input wire logic       ss_in,
  input wire logic       ss_oe_n
);
  // ****
  // write shadows; a fault may clear the master bit, so it is masked
  // ****
  byte_t ctrl_q, ctrl_d, ien_q, ien_d;
  always_comb begin
    ctrl_d = (wr && addr == `OFS_CONTROL) ? wdata : ctrl_q;
    ien_d  = (wr && addr == `OFS_IRQ_ENABLE) ? wdata : ien_q;
  end
  // shadows registered like the real registers
  always_ff @(posedge core_clk) begin
    ctrl_q <= reset ? 8'h00 : ctrl_d;
    ien_q  <= reset ? 8'h00 : ien_d;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_reset_pins: assert property ($fell(reset) |->
    sck_oe_n && mosi_oe_n && miso_oe_n && ss_oe_n && !irq) else $error("pins held after reset");
  chk_ctrl_back: assert property ($past(rd && addr == `OFS_CONTROL) |->
    (rdata & 8'hef) == ($past(ctrl_q) & 8'hef)) else $error("control read-back wrong");
  chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data without read");
  chk_miso_desel: assert property (ss_in [*5] |-> miso_oe_n)
    else $error("miso driven while deselected");
  chk_slave_in: assert property (!miso_oe_n |-> sck_oe_n && mosi_oe_n)
    else $error("slave drives more than miso");
  chk_slave_ss: assert property (!miso_oe_n |-> ss_oe_n)
    else $error("slave drives select");
  chk_fault_off: assert property ((ss_oe_n && !ss_in) [*8] |-> sck_oe_n && mosi_oe_n)
    else $error("clock or mosi driven after fault");
  chk_irq_gate: assert property (irq && $past(ien_q) == 8'h00 |->
    $past(global_irq_en && ctrl_q[`BIT_IRQ_EN])) else $error("ungated interrupt");
endmodule : spi_sel_checker

bind spi_select_and_control spi_sel_checker u_spi_sel_checker (.core_clk, .reset, .addr,
  .wdata, .wr, .rd, .rdata, .global_irq_en, .irq, .sck_oe_n, .mosi_oe_n, .miso_oe_n, .ss_in,
  .ss_oe_n);

// ===== tb/spi_far_end.sv
// far-side device: mode 0 slave, or master framing bytes with select
`timescale 1ns/1ps
module spi_far_end
  import spi_sel_pkg::*;
(
  input wire logic sck_w,
  input wire logic ss_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  output logic     sck_drv,
  output logic     mosi_drv,
  output logic     miso_drv,
  output logic     ss_drv
);
  // ****
  // idle: clock low outside frames, select high
  // ****
  byte_t tx_q = 8'ha5;
  byte_t rx_q = 8'h00;
  logic  master_on = 1'b0;
  initial begin
    sck_drv = 1'b0;
    mosi_drv = 1'b0;
    miso_drv = 1'b0;
    ss_drv = 1'b1;
  end
  // slave: first bit at select, sample rising, shift falling
  always @(negedge ss_w) if (!master_on) miso_drv = tx_q[7];
  always @(posedge sck_w) if (!ss_w) rx_q = {rx_q[6:0], master_on ? miso_w : mosi_w};
  always @(negedge sck_w) if (!ss_w && !master_on) begin
    tx_q = {tx_q[6:0], tx_q[7]};
    miso_drv = tx_q[7];
  end
  // released line must not keep the last bit
  always @(posedge ss_w) miso_drv = ~miso_drv;
  // master: n bits in one select frame, 320 ns clock
  task automatic xfer(input byte_t b, input int n);
    master_on = 1'b1;
    tx_q = b;
    ss_drv = 1'b0;
    mosi_drv = b[7];
    repeat (n) begin
      #160 sck_drv = 1'b1;
      #160 sck_drv = 1'b0;
      tx_q = tx_q << 1;
      mosi_drv = tx_q[7];
    end
    #160 ss_drv = 1'b1;
    mosi_drv = ~mosi_drv;
    master_on = 1'b0;
  endtask : xfer
endmodule : spi_far_end

// ===== tb/spi_select_and_control_tb.sv
// self-checking bench for the select and control block
`timescale 1ns/1ps
`include "spi_sel_defines.svh"
module spi_select_and_control_tb;
  import spi_sel_pkg::*;
  // ****
  // pins resolve to whichever party enables its driver
  // ****
  logic core_clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, global_irq_en = 1'b1;
  logic [2:0] addr = 3'h0;
  byte_t      wdata = 8'h00, rdata, v, t;
  logic irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, ss_out, ss_oe_n;
  logic sck_in, mosi_in, miso_in, ss_in, f_sck, f_mosi, f_miso, f_ss;
  int fails = 0, checked = 0;
  assign sck_in  = sck_oe_n ? f_sck : sck_out;
  assign mosi_in = mosi_oe_n ? f_mosi : mosi_out;
  assign miso_in = miso_oe_n ? f_miso : miso_out;
  assign ss_in   = ss_oe_n ? f_ss : ss_out;
  spi_select_and_control u_spi_select_and_control (.core_clk, .reset, .addr, .wdata, .wr,
    .rd, .rdata, .global_irq_en, .irq, .sck_in, .sck_out, .sck_oe_n, .mosi_in, .mosi_out,
    .mosi_oe_n, .miso_in, .miso_out, .miso_oe_n, .ss_in, .ss_out, .ss_oe_n);
  spi_far_end u_spi_far_end (.sck_w(sck_in), .ss_w(ss_in), .mosi_w(mosi_in),
    .miso_w(miso_in), .sck_drv(f_sck), .mosi_drv(f_mosi), .miso_drv(f_miso), .ss_drv(f_ss));
  // 25 MHz core clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input string what, input byte_t exp, input byte_t seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [2:0] a, input byte_t d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output byte_t d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd_reg
  task automatic wait_flag;
    v = 8'h00;
    for (int i = 0; i < 200 && v[7] !== 1'b1; i++) rd_reg(`OFS_STATUS, v);
    check("flag", 8'h80, v & 8'h80);
  endtask : wait_flag
  function automatic byte_t rev(input byte_t b);
    for (int i = 0; i < 8; i++) rev[i] = b[7-i];
  endfunction : rev
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // a hang is cut well after the few hundred cycles the tests need
  initial begin
    #800000;
    fails++;
    wrap_up();
  end
  // main sequence
  initial begin
    void'($urandom(32'h1a7c2ad6));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd_reg(`OFS_CONTROL, v);
    check("ctrl reset", 8'h00, v);
    repeat (4) begin
      t = 8'($urandom) & 8'hbf;
      wr_reg(`OFS_CONTROL, t);
      rd_reg(`OFS_CONTROL, v);
      check("ctrl rw", t, v);
    end
    $display("test control done");
    wr_reg(`OFS_PIN_DIR, 8'h0d);
    wr_reg(`OFS_PIN_STATE, 8'h00);
    for (int o = 0; o < 2; o++) begin
      t = 8'($urandom);
      wr_reg(`OFS_CONTROL, o ? 8'h70 : 8'hd0);
      wr_reg(`OFS_DATA, t);
      wait_flag();
      check("irq", {7'h0, o == 0}, {7'h0, irq});
      rd_reg(`OFS_DATA, v);
      check("far rx", o ? rev(t) : t, u_spi_far_end.rx_q);
      rd_reg(`OFS_CONTROL, v);
      check("master kept", o ? 8'h70 : 8'hd0, v);
    end
    $display("test master done");
    // select as input pulled low under master: fault, interrupt raise, mask, clear
    wr_reg(`OFS_PIN_DIR, 8'h05);
    wr_reg(`OFS_IRQ_ENABLE, 8'h02);
    wr_reg(`OFS_CONTROL, 8'h50);
    u_spi_far_end.ss_drv = 1'b0;
    repeat (10) @(negedge core_clk);
    check("oe after fault", 8'h03, {6'h0, sck_oe_n, mosi_oe_n});
    check("irq raised", 8'h01, {7'h0, irq});
    wr_reg(`OFS_IRQ_ENABLE, 8'h00);
    repeat (2) @(negedge core_clk);
    check("irq masked", 8'h00, {7'h0, irq});
    wr_reg(`OFS_IRQ_CLEAR, 8'h02);
    wr_reg(`OFS_IRQ_ENABLE, 8'h02);
    repeat (2) @(negedge core_clk);
    check("irq cleared", 8'h00, {7'h0, irq});
    u_spi_far_end.ss_drv = 1'b1;
    wait_flag();
    rd_reg(`OFS_CONTROL, v);
    check("still slave", 8'h40, v);
    rd_reg(`OFS_DATA, v);
    // software takes the master role back once select is released
    wr_reg(`OFS_CONTROL, 8'h50);
    rd_reg(`OFS_CONTROL, v);
    check("master again", 8'h50, v);
    $display("test fault done");
    // slave: broken frame, then a whole byte each way
    wr_reg(`OFS_CONTROL, 8'h40);
    wr_reg(`OFS_PIN_DIR, 8'h02);
    t = 8'($urandom);
    u_spi_far_end.xfer(t, 3);
    // select is seen late through the synchroniser; wait before loading data
    repeat (4) @(posedge core_clk);
    wr_reg(`OFS_DATA, t);
    u_spi_far_end.xfer(~t, 8);
    wait_flag();
    rd_reg(`OFS_DATA, v);
    check("slave rx", ~t, v);
    check("slave tx", t, u_spi_far_end.rx_q);
    $display("test slave done");
    wr_reg(`OFS_CONTROL, 8'h00);
    u_spi_far_end.xfer(t, 8);
    rd_reg(`OFS_STATUS, v);
    check("disabled", 8'h00, v & 8'hc0);
    $display("test disable done");
    wrap_up();
  end
endmodule : spi_select_and_control_tb
